// ==== logic/afp_pkg.sv ====
// Shared constants, status codes and register map of the audio packetizer.
package afp_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned ENTRY_W = 36;
  localparam int unsigned FIFO_DEPTH = 35;
  localparam int unsigned FULL_LEVEL = 34;
  localparam int unsigned ALMOST_FULL_LEVEL = 32;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned LINE_W = 12;
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned GPIO_W = 14;
  localparam int unsigned GPIO_LO = 8;
  // Status nibble encodings shared with the DMA reader.
  localparam logic [3:0] CODE_VALID = 4'h0;
  localparam logic [3:0] CODE_SOL = 4'h1;
  localparam logic [3:0] CODE_FIELD_START = 4'h6;
  localparam logic [3:0] CODE_PLANAR_THIRD = 4'h7;
  localparam logic [3:0] CODE_EOL1 = 4'h8;
  localparam logic [3:0] CODE_FIELD_END = 4'hc;
  localparam logic [3:0] CODE_EVEN_END = 4'hd;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LINE = 8'h04;
  localparam logic [7:0] REG_FIELD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // Control register fields.
  localparam int unsigned CTRL_W = 6;
  localparam int unsigned CTRL_CAPTURE = 0;
  localparam int unsigned CTRL_FIFO_EN = 1;
  localparam int unsigned CTRL_SIZE8 = 2;
  localparam int unsigned CTRL_DIGITAL = 3;
  localparam int unsigned CTRL_PACKET = 4;
  localparam int unsigned CTRL_DEBUG = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [15:0] LINE_RESET = 16'h0100;
  localparam logic [15:0] FIELD_RESET = 16'h0001;
  // Status register fields.
  localparam int unsigned STAT_FULL = 6;
  localparam int unsigned STAT_AFULL = 7;
  localparam int unsigned STAT_BUSY = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {AFP_IDLE, AFP_FSTART, AFP_LINE, AFP_FEND} afp_state_t;
endpackage : afp_pkg

// ==== logic/afp_fifo.sv ====
// Audio FIFO with occupancy counter, single clock.
`timescale 1ns/1ps
module afp_fifo import afp_pkg::*; #(
  parameter int unsigned WIDTH = ENTRY_W,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned FULL = FULL_LEVEL,
  parameter int unsigned AFULL = ALMOST_FULL_LEVEL
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [CNT_W-1:0] count,
  output logic full,
  output logic almost_full
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  if (DEPTH < 2 || DEPTH > 2 ** CNT_W - 1 || FULL > DEPTH || AFULL > FULL) begin : g_bad_size
    $error("afp_fifo: depth and levels do not fit the counter");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wptr_q, rptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic rd;

  // Both ports run on the one clock, so the counter needs no crossing.
  assign rd = rd_ready && cnt_q != '0;
  assign rd_valid = cnt_q != '0;
  assign rd_data = mem_q[rptr_q];
  assign count = cnt_q;
  assign full = cnt_q >= CNT_W'(FULL);
  assign almost_full = cnt_q >= CNT_W'(AFULL);
  assign wr_ready = !full;

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_q[wptr_q] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (wr_en) begin
        wptr_q <= (wptr_q == PTR_W'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (rd) begin
        rptr_q <= (rptr_q == PTR_W'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      cnt_q <= '0;
    end else if (wr_en && !rd) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (rd && !wr_en) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  a_count_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && wr_en && !rd |=> !enable || cnt_q == $past(cnt_q) + 1'b1)
    else $error("occupancy did not follow a write");
  a_count_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> cnt_q == '0)
    else $error("occupancy not cleared while disabled");
  a_depth_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_q <= CNT_W'(DEPTH) && (full == (cnt_q >= CNT_W'(FULL))))
    else $error("occupancy beyond depth or wrong full level");
endmodule : afp_fifo

// ==== logic/afp_source_mux.sv ====
// Selects the sample source and presents one item of one, two or four bytes.
`timescale 1ns/1ps
module afp_source_mux import afp_pkg::*; (
  input wire logic digital_sel,
  input wire logic packet_mode,
  input wire logic sample_size_select,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  output logic conv_ready,
  input wire logic dig_valid,
  input wire logic [15:0] dig_left,
  input wire logic [15:0] dig_right,
  output logic dig_ready,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_byte,
  output logic pkt_ready,
  output logic item_valid,
  output logic [DATA_W-1:0] item_data,
  output logic [2:0] item_bytes,
  input wire logic item_ready
);
  always_comb begin
    conv_ready = 1'b0;
    dig_ready = 1'b0;
    pkt_ready = 1'b0;
    if (digital_sel && packet_mode) begin
      item_valid = pkt_valid;
      item_data = {24'h000000, pkt_byte};
      item_bytes = 3'd1;
      pkt_ready = item_ready;
    end else if (digital_sel) begin
      // A left/right pair is one item so it always lands in a single word.
      item_valid = dig_valid;
      item_data = {dig_right, dig_left};
      item_bytes = 3'd4;
      dig_ready = item_ready;
    end else begin
      item_valid = conv_valid;
      item_data = sample_size_select ? {24'h000000, conv_data[7:0]} : {16'h0000, conv_data};
      item_bytes = sample_size_select ? 3'd1 : 3'd2;
      conv_ready = item_ready;
    end
  end
endmodule : afp_source_mux

// ==== logic/afp_packetizer.sv ====
// Audio packetizer top: register slave, line and field framing, FIFO write side.
`timescale 1ns/1ps
module afp_packetizer import afp_pkg::*; #(
  parameter int unsigned LW = LINE_W,
  parameter int unsigned FW = FIELD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  output logic conv_ready,
  input wire logic dig_valid,
  input wire logic [15:0] dig_left,
  input wire logic [15:0] dig_right,
  output logic dig_ready,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_byte,
  output logic pkt_ready,
  output logic afifo_rvalid,
  input wire logic afifo_rready,
  output logic [ENTRY_W-1:0] afifo_rdata,
  output logic [CNT_W-1:0] afifo_count,
  output logic afifo_full,
  output logic afifo_almost_full,
  output logic [GPIO_W-1:0] gpio_o,
  output logic [GPIO_W-1:0] gpio_oe
);
  if (LW < 3 || LW > 16 || FW < 1 || FW > 16) begin : g_bad_width
    $error("afp_packetizer: length widths must lie in 3..16 and 1..16");
  end

  logic [CTRL_W-1:0] ctrl_q;
  logic [LW-1:0] line_cfg_q, line_len_q, byte_cnt_q, remain;
  logic [FW-1:0] field_cfg_q, field_len_q, line_cnt_q;
  afp_state_t state_q;
  logic [1:0] lane_q;
  logic [DATA_W-1:0] acc_q, merged, keep;
  logic first_word_q, wr_q, fifo_wr, fifo_wready, can_emit, in_ready, take_item;
  logic [ENTRY_W-1:0] wdata_q;
  logic [2:0] take, room, fill;
  logic line_done, word_done, last_line, cfg_empty;
  logic [CODE_W-1:0] code;
  logic item_valid;
  logic [DATA_W-1:0] item_data;
  logic [2:0] item_bytes;
  logic capture_on, fifo_en;
  logic aw_q, w_q, bvalid_q, rvalid_q, do_write;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_bus_q, rdata_q, ctrl_new, line_new, field_new;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [GPIO_W-1:0] gpio_q;

  function automatic logic [31:0] afp_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : afp_merge

  assign capture_on = ctrl_q[CTRL_CAPTURE];
  assign fifo_en = ctrl_q[CTRL_FIFO_EN];

  afp_source_mux u_src (
    .digital_sel(ctrl_q[CTRL_DIGITAL]),
    .packet_mode(ctrl_q[CTRL_PACKET]),
    .sample_size_select(ctrl_q[CTRL_SIZE8]),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .conv_ready(conv_ready),
    .dig_valid(dig_valid),
    .dig_left(dig_left),
    .dig_right(dig_right),
    .dig_ready(dig_ready),
    .pkt_valid(pkt_valid),
    .pkt_byte(pkt_byte),
    .pkt_ready(pkt_ready),
    .item_valid(item_valid),
    .item_data(item_data),
    .item_bytes(item_bytes),
    .item_ready(in_ready)
  );

  // Register slave; write address and data may arrive in either order.
  assign awready = !aw_q && !bvalid_q;
  assign wready = !w_q && !bvalid_q;
  assign do_write = aw_q && w_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign ctrl_new = afp_merge({26'h0, ctrl_q}, wdata_bus_q, wstrb_q);
  assign line_new = afp_merge(32'(line_cfg_q), wdata_bus_q, wstrb_q);
  assign field_new = afp_merge(32'(field_cfg_q), wdata_bus_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_bus_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wdata_bus_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == REG_CTRL || awaddr_q == REG_LINE || awaddr_q == REG_FIELD ||
                    awaddr_q == REG_STATUS) ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      line_cfg_q <= LW'(LINE_RESET);
      field_cfg_q <= FW'(FIELD_RESET);
    end else if (do_write) begin
      if (awaddr_q == REG_CTRL) begin
        ctrl_q <= ctrl_new[CTRL_W-1:0];
      end
      if (awaddr_q == REG_LINE) begin
        line_cfg_q <= line_new[LW-1:0];
      end
      if (awaddr_q == REG_FIELD) begin
        field_cfg_q <= field_new[FW-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      unique case (araddr)
        REG_CTRL: rdata_q <= 32'(ctrl_q);
        REG_LINE: rdata_q <= 32'(line_cfg_q);
        REG_FIELD: rdata_q <= 32'(field_cfg_q);
        REG_STATUS: rdata_q <= 32'({state_q != AFP_IDLE, afifo_almost_full, afifo_full, afifo_count});
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= RESP_DECERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Packing of one item into the word being assembled.
  assign remain = line_len_q - byte_cnt_q;
  assign can_emit = !wr_q && fifo_wready && fifo_en;
  assign in_ready = state_q == AFP_LINE && can_emit;
  assign take_item = item_valid && in_ready;
  assign last_line = line_cnt_q == field_len_q - FW'(1);
  assign cfg_empty = line_cfg_q == '0 || field_cfg_q == '0;

  always_comb begin
    room = 3'd4 - {1'b0, lane_q};
    take = item_bytes;
    if (take > room) begin
      take = room;
    end
    if (LW'(take) > remain) begin
      take = remain[2:0];
    end
    fill = {1'b0, lane_q} + take;
    line_done = (byte_cnt_q + LW'(take)) == line_len_q;
    word_done = fill == 3'd4 || line_done;
    keep = ~(32'hffffffff << {take, 3'b000});
    merged = acc_q | ((item_data & keep) << {lane_q, 3'b000});
    if (line_done) begin
      code = CODE_EOL1 + CODE_W'(fill - 3'd1);
    end else if (first_word_q) begin
      code = CODE_SOL;
    end else begin
      code = CODE_VALID;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !fifo_en) begin
      state_q <= AFP_IDLE;
    end else begin
      unique case (state_q)
        AFP_IDLE: if (capture_on) state_q <= AFP_FSTART;
        AFP_FSTART: if (can_emit) state_q <= cfg_empty ? AFP_FEND : AFP_LINE;
        AFP_LINE: if (take_item && line_done && last_line) state_q <= AFP_FEND;
        AFP_FEND: if (can_emit) state_q <= capture_on ? AFP_FSTART : AFP_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_len_q <= '0;
      field_len_q <= '0;
      line_cnt_q <= '0;
      byte_cnt_q <= '0;
      lane_q <= 2'h0;
      acc_q <= 32'h00000000;
      first_word_q <= 1'b0;
    end else if (state_q == AFP_FSTART && can_emit) begin
      line_len_q <= line_cfg_q;
      field_len_q <= field_cfg_q;
      line_cnt_q <= '0;
      byte_cnt_q <= '0;
      lane_q <= 2'h0;
      acc_q <= 32'h00000000;
      first_word_q <= 1'b1;
    end else if (take_item) begin
      if (line_done) begin
        byte_cnt_q <= '0;
        line_cnt_q <= line_cnt_q + FW'(1);
        first_word_q <= 1'b1;
      end else begin
        byte_cnt_q <= byte_cnt_q + LW'(take);
      end
      if (word_done) begin
        lane_q <= 2'h0;
        acc_q <= 32'h00000000;
        if (!line_done) begin
          first_word_q <= 1'b0;
        end
      end else begin
        lane_q <= lane_q + take[1:0];
        acc_q <= merged;
      end
    end
  end

  // A write is a single-cycle pulse, so the following cycle is always idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      wr_q <= 1'b0;
      if (state_q == AFP_FSTART && can_emit) begin
        wr_q <= 1'b1;
        wdata_q <= {CODE_FIELD_START, 32'h00000000};
      end else if (state_q == AFP_FEND && can_emit) begin
        wr_q <= 1'b1;
        wdata_q <= {CODE_FIELD_END, 32'h00000000};
      end else if (take_item && word_done) begin
        wr_q <= 1'b1;
        wdata_q <= {code, merged};
      end
    end
  end

  // Disabling the FIFO gates the pending strobe in the same cycle.
  assign fifo_wr = wr_q && fifo_en;

  afp_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(fifo_en),
    .wr_en(fifo_wr),
    .wr_data(wdata_q),
    .wr_ready(fifo_wready),
    .rd_valid(afifo_rvalid),
    .rd_ready(afifo_rready),
    .rd_data(afifo_rdata),
    .count(afifo_count),
    .full(afifo_full),
    .almost_full(afifo_almost_full)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_q <= '0;
    end else begin
      gpio_q <= ctrl_q[CTRL_DEBUG] ? {afifo_count, 8'h00} : '0;
    end
  end
  assign gpio_o = gpio_q;
  assign gpio_oe = ctrl_q[CTRL_DEBUG] ? {{CNT_W{1'b1}}, 8'h00} : '0;

  logic await_first_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == AFP_IDLE) begin
      await_first_q <= 1'b1;
    end else if (fifo_wr) begin
      await_first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_final_field_end;
    fifo_wr && wdata_q[35:32] == CODE_FIELD_END && !capture_on && fifo_en;
  endsequence

  a_write_gap: assert property (fifo_wr |=> !fifo_wr)
    else $error("two consecutive FIFO writes");
  a_banned_codes: assert property (fifo_wr |->
    wdata_q[35:32] != CODE_PLANAR_THIRD && wdata_q[35:32] != CODE_EVEN_END)
    else $error("forbidden status code written");
  a_first_field_start: assert property (fifo_wr && await_first_q |->
    wdata_q[35:32] == CODE_FIELD_START)
    else $error("capture did not open with field start");
  a_eol_justified: assert property (fifo_wr && wdata_q[35:34] == 2'b10 |->
    (wdata_q[31:0] >> {wdata_q[33:32] + 3'd1, 3'b000}) == 32'h0)
    else $error("bytes beyond line-end count are not zero");
  a_field_end_lines: assert property (fifo_wr && wdata_q[35:32] == CODE_FIELD_END |->
    line_cnt_q == field_len_q || line_len_q == '0 || field_len_q == '0)
    else $error("field end before the programmed line count");
  a_stop_after_end: assert property (s_final_field_end |=> state_q == AFP_IDLE ##1 !fifo_wr)
    else $error("writing continued after the final field end");
  a_disable_halts: assert property (!fifo_en |-> !fifo_wr ##1 state_q == AFP_IDLE)
    else $error("FIFO disable did not halt the sequencer");
  a_length_latch: assert property ($changed(line_len_q) || $changed(field_len_q) |->
    $past(state_q) == AFP_FSTART)
    else $error("line or field length changed mid field");
  a_debug_gpio: assert property (ctrl_q[CTRL_DEBUG] |=>
    ctrl_q[CTRL_DEBUG] == 1'b0 || gpio_o[13:8] == $past(afifo_count))
    else $error("debug pins do not show occupancy");
endmodule : afp_packetizer

// ==== sim/afp_dma_model.sv ====
// Audio DMA reader model that drains the audio FIFO and records each word it pops.
`timescale 1ns/1ps
module afp_dma_model import afp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire logic slow,
  input wire logic afifo_rvalid,
  input wire logic [ENTRY_W-1:0] afifo_rdata,
  output logic afifo_rready
);
  logic [ENTRY_W-1:0] seen [$];
  // The reader runs on the writer's clock, so no synchroniser sits on this side.
  always @(posedge aclk) begin
    if (!aresetn) begin
      afifo_rready <= 1'b0;
    end else begin
      afifo_rready <= !stall && !(slow && afifo_rready);
    end
  end
  // A stalled reader lets the FIFO climb to its full level; a slow one pops every other cycle.
  always @(posedge aclk) begin
    if (aresetn && afifo_rvalid && afifo_rready) begin
      seen.push_back(afifo_rdata);
    end
  end
endmodule : afp_dma_model

// ==== sim/tb_afp_packetizer.sv ====
// Self-checking bench for the audio packetizer with a DMA reader on the FIFO side.
`timescale 1ns/1ps
module tb_afp_packetizer import afp_pkg::*; ;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, pkt_byte;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic conv_valid, conv_ready, dig_valid, dig_ready, pkt_valid, pkt_ready, stall, slow;
  logic [15:0] conv_data, dig_left, dig_right;
  logic afifo_rvalid, afifo_rready, afifo_full, afifo_almost_full;
  logic [ENTRY_W-1:0] afifo_rdata;
  logic [CNT_W-1:0] afifo_count;
  logic [GPIO_W-1:0] gpio_o, gpio_oe;
  int fails, num_checks;
  // Rows: control, line bytes, field lines, word count, expected FIFO words.
  logic [5:0] c_ctrl [5] = '{6'h03, 6'h0b, 6'h1b, 6'h07, 6'h03};
  logic [11:0] c_len [5] = '{12'd6, 12'd8, 12'd5, 12'd3, 12'd7};
  logic [7:0] c_fld [5] = '{8'd2, 8'd1, 8'd2, 8'd1, 8'd1};
  int c_n [5] = '{6, 4, 6, 3, 4};
  logic [35:0] c_exp [5][6] = '{
    '{36'h600000000, 36'h101010100, 36'h900000102, 36'h101040103, 36'h900000105, 36'hc00000000},
    '{36'h600000000, 36'h112000200, 36'hb12010201, 36'hc00000000, 36'h0, 36'h0},
    '{36'h600000000, 36'h113121110, 36'h800000014, 36'h118171615, 36'h800000019, 36'hc00000000},
    '{36'h600000000, 36'ha00020100, 36'hc00000000, 36'h0, 36'h0, 36'h0},
    '{36'h600000000, 36'h101010100, 36'ha00030102, 36'hc00000000, 36'h0, 36'h0}};
  logic [7:0] r_addr [5] = '{REG_CTRL, REG_LINE, REG_FIELD, REG_STATUS, 8'h10};
  logic [35:0] r_exp [5] = '{36'h0, 36'h100, 36'h1, 36'h0, 36'h300000000};

  afp_packetizer i_afp_packetizer (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .conv_valid, .conv_data,
    .conv_ready, .dig_valid, .dig_left, .dig_right, .dig_ready, .pkt_valid, .pkt_byte, .pkt_ready,
    .afifo_rvalid, .afifo_rready, .afifo_rdata, .afifo_count, .afifo_full, .afifo_almost_full,
    .gpio_o, .gpio_oe
  );
  afp_dma_model i_afp_dma_model (
    .aclk, .aresetn, .stall, .slow, .afifo_rvalid, .afifo_rdata, .afifo_rready
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Each source counts up once per accepted item, so every word's origin is visible.
  always @(posedge aclk) begin
    if (conv_valid && conv_ready) conv_data <= conv_data + 16'h1;
    if (dig_valid && dig_ready) dig_left <= dig_left + 16'h1;
    if (dig_valid && dig_ready) dig_right <= dig_right + 16'h1;
    if (pkt_valid && pkt_ready) pkt_byte <= pkt_byte + 8'h1;
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  // Handshakes are judged at the falling edge, so the decision never races the rising one.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic run_case(input int i);
    @(posedge aclk);
    conv_data <= 16'h0100;
    dig_left <= 16'h0200;
    dig_right <= 16'h1200;
    pkt_byte <= 8'h10;
    slow <= (i == 2);
    axi_wr(REG_LINE, 32'(c_len[i]));
    axi_wr(REG_FIELD, 32'(c_fld[i]));
    axi_wr(REG_CTRL, 32'(c_ctrl[i]));
    // Capture drops mid-field; the field must still close with its end word.
    axi_wr(REG_CTRL, 32'(c_ctrl[i] & 6'h3e));
    while (i_afp_dma_model.seen.size() < c_n[i]) @(negedge aclk);
    repeat (40) @(negedge aclk);
    check(36'(i_afp_dma_model.seen.size()), 36'(c_n[i]));
    check(36'(afifo_count), 36'h0);
    for (int k = 0; k < c_n[i]; k++) check(i_afp_dma_model.seen[k], c_exp[i][k]);
    axi_wr(REG_CTRL, 32'h0);
    i_afp_dma_model.seen.delete();
  endtask : run_case

  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end

  initial begin
    fails = 0;
    num_checks = 0;
    aresetn <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    wstrb <= 4'hf;
    conv_valid <= 1'b1;
    dig_valid <= 1'b1;
    pkt_valid <= 1'b1;
    conv_data <= 16'h0;
    dig_left <= 16'h0;
    dig_right <= 16'h0;
    pkt_byte <= 8'h00;
    stall <= 1'b0;
    slow <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) run_case(i);
    // Stalled reader with a long line: the FIFO must stop at its full level.
    @(posedge aclk);
    stall <= 1'b1;
    axi_wr(REG_LINE, 32'h100);
    axi_wr(REG_CTRL, 32'h23);
    while (afifo_count !== 6'd32) @(negedge aclk);
    check(36'({afifo_full, afifo_almost_full}), 36'h1);
    while (afifo_count !== 6'd34) @(negedge aclk);
    repeat (10) @(negedge aclk);
    check(36'({afifo_full, afifo_almost_full, afifo_count}), 36'({2'b11, 6'd34}));
    check(36'({gpio_oe, gpio_o}), 36'({14'h3f00, 6'd34, 8'h00}));
    axi_wr(REG_CTRL, 32'h21);
    repeat (2) @(negedge aclk);
    check(36'({afifo_rvalid, afifo_count}), 36'h0);
    @(posedge aclk);
    stall <= 1'b0;
    run_case(0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      axi_rd(r_addr[k]);
      check(36'({r, d}), r_exp[k]);
    end
    axi_wr(8'h10, 32'h1);
    check(36'(r), 36'(RESP_DECERR));
    tally_and_finish();
  end
endmodule : tb_afp_packetizer
